// ==== verilog/alias_params.svh ====
`ifndef ALIAS_PARAMS_SVH
`define ALIAS_PARAMS_SVH

// Register offsets
`define ALIAS_ENTRY_4_OFFSET  8'h14
`define ALIAS_ENTRY_5_OFFSET  8'h15
`define ALIAS_ENTRY_6_OFFSET  8'h16
`define ALIAS_ENTRY_7_OFFSET  8'h17
`define SCRATCH_OFFSET        8'h18

// Field positions inside an alias entry byte
`define ALIAS_FIELD_MSB       7
`define ALIAS_FIELD_LSB       1

// Reset values
`define ALIAS_RESET           7'h00
`define SCRATCH_RESET         8'h00
`define UNMAPPED_READ         8'h00

// Alias value that switches an entry off
`define ALIAS_DISABLED        7'h00

`endif

// ==== verilog/alias_pkg.sv ====
package alias_pkg;

    typedef logic [6:0] i2c_addr_t;

    // One I2C transaction header seen by the local decoder
    typedef struct packed {
        i2c_addr_t addr;
        logic      rd_not_wr;
    } txn_t;

    // Header forwarded across the link, with the entry that matched
    typedef struct packed {
        i2c_addr_t addr;
        logic      rd_not_wr;
        logic [1:0] entry;
    } fwd_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

// ==== verilog/i2c_remote_alias_decoder.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "alias_params.svh"

// How it works
// - Each alias entry holds a 7-bit alias in bits 7..1, reset zero.
// - Each transaction address is compared with every alias entry.
// - A match is forwarded with its address replaced by the paired one.
// - An alias of zero disables its entry; it never matches.
// - An 8-bit scratch byte stores writes and affects nothing else.
// - The scratch byte is readable and writable from both link ends.
module i2c_remote_alias_decoder #(
    parameter int N_ENTRIES = 4
) (
    // Clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   reset_i,
    // Local register port
    input  wire alias_pkg::reg_req_t    reg_req_i,
    output logic [7:0]                  reg_rdata_o,
    // Remote end access to the scratch byte
    input  wire logic                   remote_scratch_wr_i,
    input  wire logic                   remote_scratch_rd_i,
    input  wire logic [7:0]             remote_scratch_wdata_i,
    output logic [7:0]                  remote_scratch_rdata_o,
    // Paired remote target addresses, entries 4 to 7
    input  wire alias_pkg::i2c_addr_t   remote_target_address_i [N_ENTRIES],
    // Local transaction headers
    input  wire logic                   txn_valid_i,
    input  wire alias_pkg::txn_t        txn_i,
    // Forwarded and local-only results
    output logic                        fwd_valid_o,
    output alias_pkg::fwd_t             fwd_o,
    output logic                        local_valid_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    function automatic logic [7:0] entry_offset(input int idx);
        entry_offset = `ALIAS_ENTRY_4_OFFSET + 8'(idx);
    endfunction

    alias_pkg::i2c_addr_t alias_q [N_ENTRIES];
    alias_pkg::i2c_addr_t alias_d [N_ENTRIES];
    logic [7:0]           scratch_q;
    logic [7:0]           scratch_d;
    logic [7:0]           reg_rdata_q;
    logic [7:0]           reg_rdata_d;
    logic [7:0]           remote_rdata_q;
    logic [7:0]           remote_rdata_d;

    genvar g;
    generate
        for (g = 0; g < N_ENTRIES; g++) begin : g_alias
            always_comb begin
                alias_d[g] = alias_q[g];
                if (reg_req_i.wr && addr_hit(reg_req_i.addr,
                                             entry_offset(g))) begin
                    // Bit 0 of the byte is dropped here
                    alias_d[g] =
                        reg_req_i.wdata[`ALIAS_FIELD_MSB:`ALIAS_FIELD_LSB];
                end
            end

            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    alias_q[g] <= `ALIAS_RESET;
                end else begin
                    alias_q[g] <= alias_d[g];
                end
            end
        end
    endgenerate

    // Local write wins if both ends write the scratch byte in one cycle
    always_comb begin
        scratch_d = scratch_q;
        if (reg_req_i.wr && addr_hit(reg_req_i.addr, `SCRATCH_OFFSET)) begin
            scratch_d = reg_req_i.wdata;
        end else if (remote_scratch_wr_i) begin
            scratch_d = remote_scratch_wdata_i;
        end
    end

    always_comb begin
        reg_rdata_d = `UNMAPPED_READ;
        if (reg_req_i.rd) begin
            if (addr_hit(reg_req_i.addr, `SCRATCH_OFFSET)) begin
                reg_rdata_d = scratch_q;
            end else begin
                for (int i = 0; i < N_ENTRIES; i++) begin
                    if (addr_hit(reg_req_i.addr, entry_offset(i))) begin
                        reg_rdata_d = {alias_q[i], 1'b0};
                    end
                end
            end
        end
    end

    always_comb begin
        remote_rdata_d = `UNMAPPED_READ;
        if (remote_scratch_rd_i) begin
            remote_rdata_d = scratch_q;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            scratch_q      <= `SCRATCH_RESET;
            reg_rdata_q    <= `UNMAPPED_READ;
            remote_rdata_q <= `UNMAPPED_READ;
        end else begin
            scratch_q      <= scratch_d;
            reg_rdata_q    <= reg_rdata_d;
            remote_rdata_q <= remote_rdata_d;
        end
    end

    assign reg_rdata_o            = reg_rdata_q;
    assign remote_scratch_rdata_o = remote_rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Alias matching; the lowest matching entry wins

    logic            fwd_valid_q;
    logic            fwd_valid_d;
    alias_pkg::fwd_t fwd_q;
    alias_pkg::fwd_t fwd_d;
    logic            local_valid_q;
    logic            local_valid_d;

    always_comb begin
        logic hit;
        hit           = 1'b0;
        fwd_d         = fwd_q;
        for (int i = N_ENTRIES - 1; i >= 0; i--) begin
            // Compare only the 7-bit address, never the R/W bit;
            // idle headers must not disturb the held forward header
            if (txn_valid_i && txn_i.addr == alias_q[i] &&
                alias_q[i] != `ALIAS_DISABLED) begin
                hit             = 1'b1;
                fwd_d.addr      = remote_target_address_i[i];
                fwd_d.rd_not_wr = txn_i.rd_not_wr;
                fwd_d.entry     = 2'(i);
            end
        end
        fwd_valid_d   = txn_valid_i && hit;
        local_valid_d = txn_valid_i && !hit;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            fwd_valid_q   <= 1'b0;
            fwd_q         <= '0;
            local_valid_q <= 1'b0;
        end else begin
            fwd_valid_q   <= fwd_valid_d;
            fwd_q         <= fwd_d;
            local_valid_q <= local_valid_d;
        end
    end

    assign fwd_valid_o   = fwd_valid_q;
    assign fwd_o         = fwd_q;
    assign local_valid_o = local_valid_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_ALIAS_RESET: assert property (
        @(posedge clk_sys_i) reset_i |=> alias_q[0] == 7'h00
    ) else $error("alias entry not cleared by reset");

    AST_ALIAS_WRITE: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        reg_req_i.wr && reg_req_i.addr == 8'h15 ##1 reg_req_i.rd &&
        reg_req_i.addr == 8'h15 && !$past(reset_i)
        |=> reg_rdata_o[7:1] == $past(reg_req_i.wdata[7:1], 2)
    ) else $error("alias entry did not store written value");

    AST_MATCH_FWD: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        txn_valid_i && txn_i.addr == alias_q[0] && alias_q[0] != 7'h00
        |=> fwd_valid_o && !local_valid_o
    ) else $error("matching transaction not forwarded");

    AST_ADDR_SWAP: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        txn_valid_i && txn_i.addr == alias_q[0] && alias_q[0] != 7'h00
        |=> fwd_o.addr == $past(remote_target_address_i[0]) &&
            fwd_o.entry == 2'h0
    ) else $error("forwarded address not replaced");

    AST_ZERO_OFF: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        txn_valid_i && txn_i.addr == 7'h00 |=> !fwd_valid_o && local_valid_o
    ) else $error("zero alias matched a transaction");

    AST_SCRATCH_RW: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        reg_req_i.wr && reg_req_i.addr == 8'h18
        |=> scratch_q == $past(reg_req_i.wdata)
    ) else $error("scratch byte did not store local write");

    AST_SCRATCH_REMOTE: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        remote_scratch_rd_i |=> remote_scratch_rdata_o == $past(scratch_q)
    ) else $error("remote read of scratch byte wrong");

    AST_BIT0_ZERO: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        reg_req_i.rd && reg_req_i.addr >= 8'h14 && reg_req_i.addr <= 8'h17
        |=> reg_rdata_o[0] == 1'b0
    ) else $error("alias entry bit 0 not zero");

endmodule

`default_nettype wire

// ==== test/remote_end.sv ====
`timescale 1ns/100ps
`default_nettype none
// Far side: remote controller on the scratch byte, remote target map
module remote_end (
    // Clock
    input  wire logic            clk_sys_i,
    // Scratch access from the far end
    output logic                 wr_o,
    output logic                 rd_o,
    output logic [7:0]           wdata_o,
    input  wire logic [7:0]      rdata_i,
    // Paired remote target addresses
    output alias_pkg::i2c_addr_t tgt_o [4]
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // Distinct values so a swap through the wrong entry shows
    assign tgt_o = '{7'h21, 7'h32, 7'h43, 7'h54};
    task put(input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_o <= 1'b1;
        wdata_o <= d;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        // Released data must not look like the value just sent
        wdata_o <= ~d;
    endtask
    task get(output logic [7:0] d);
        @(posedge clk_sys_i);
        rd_o <= 1'b1;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                 clk_sys_i = 1'b0;
    logic                 reset_i = 1'b1;
    alias_pkg::reg_req_t  reg_req_i = '0;
    logic [7:0]           reg_rdata_o;
    logic                 rs_wr;
    logic                 rs_rd;
    logic [7:0]           rs_wdata;
    logic [7:0]           rs_rdata;
    alias_pkg::i2c_addr_t tgt [4];
    logic                 txn_valid_i = 1'b0;
    alias_pkg::txn_t      txn_i = '0;
    logic                 fwd_valid_o;
    alias_pkg::fwd_t      fwd_o;
    logic                 local_valid_o;
    int                   errors = 0;
    int                   compares = 0;
    logic [7:0]           v;

    always #2.5 clk_sys_i = ~clk_sys_i;

    i2c_remote_alias_decoder u_i2c_remote_alias_decoder (
        .clk_sys_i, .reset_i, .reg_req_i, .reg_rdata_o,
        .remote_scratch_wr_i(rs_wr), .remote_scratch_rd_i(rs_rd),
        .remote_scratch_wdata_i(rs_wdata), .remote_scratch_rdata_o(rs_rdata),
        .remote_target_address_i(tgt), .txn_valid_i, .txn_i,
        .fwd_valid_o, .fwd_o, .local_valid_o);
    remote_end u_remote_end (.clk_sys_i, .wr_o(rs_wr), .rd_o(rs_rd),
        .wdata_o(rs_wdata), .rdata_i(rs_rdata), .tgt_o(tgt));

    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_req_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        reg_req_i <= '{~a, ~d, 1'b0, 1'b0};
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_req_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        reg_req_i <= '{~a, 8'hff, 1'b0, 1'b0};
        #1 d = reg_rdata_o;
    endtask
    // Exactly one of the two valids answers one cycle after the header
    task hdr(input logic [6:0] a, input logic rw, input logic hit,
             input logic [6:0] ea, input logic [1:0] en);
        @(posedge clk_sys_i);
        txn_valid_i <= 1'b1;
        txn_i <= '{a, rw};
        @(posedge clk_sys_i);
        txn_valid_i <= 1'b0;
        txn_i <= '{~a, ~rw};
        #1 chk("valids", {6'h00, hit, ~hit},
               {6'h00, fwd_valid_o, local_valid_o});
        if (hit) begin
            chk("fwd", {ea, rw}, {fwd_o.addr, fwd_o.rd_not_wr});
            chk("entry", {6'h00, en}, {6'h00, fwd_o.entry});
        end
    endtask
    task stop_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task test_regs;
        for (int i = 0; i < 6; i++) begin
            rd(8'h14 + 8'(i), v);
            chk("reset", 8'h00, v);
        end
        for (int i = 0; i < 4; i++) wr(8'h14 + 8'(i), 8'(255 - i));
        wr(8'h19, 8'h77);
        for (int i = 0; i < 4; i++) begin
            rd(8'h14 + 8'(i), v);
            chk("alias", 8'(255 - i) & 8'hfe, v);
        end
        rd(8'h19, v);
        chk("unmapped", 8'h00, v);
        $display("test regs done");
    endtask
    // Write then read with no gap; the read data stand for one cycle only
    task test_b2b;
        @(posedge clk_sys_i);
        reg_req_i <= '{8'h15, 8'ha4, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        reg_req_i <= '{8'h15, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        reg_req_i <= '{8'hea, 8'hff, 1'b0, 1'b0};
        #1 chk("b2b read", 8'ha4, reg_rdata_o);
        @(posedge clk_sys_i);
        #1 chk("read idle", 8'h00, reg_rdata_o);
        $display("test b2b done");
    endtask
    task test_reset;
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(8'h18, v);
        chk("reset scratch", 8'h00, v);
        rd(8'h17, v);
        chk("reset alias", 8'h00, v);
        hdr(7'h52, 1'b0, 1'b0, 7'h00, 2'd0);
        $display("test reset done");
    endtask
    task test_match;
        wr(8'h14, 8'ha5);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h86);
        wr(8'h17, 8'ha4);
        hdr(7'h52, 1'b1, 1'b1, tgt[0], 2'd0);
        hdr(7'h52, 1'b0, 1'b1, tgt[0], 2'd0);
        hdr(7'h43, 1'b1, 1'b1, tgt[2], 2'd2);
        hdr(7'h00, 1'b0, 1'b0, 7'h00, 2'd0);
        hdr(7'h29, 1'b1, 1'b0, 7'h00, 2'd0);
        wr(8'h14, 8'h30);
        wr(8'h16, 8'h00);
        hdr(7'h52, 1'b1, 1'b1, tgt[3], 2'd3);
        hdr(7'h43, 1'b0, 1'b0, 7'h00, 2'd0);
        hdr(7'h18, 1'b0, 1'b1, tgt[0], 2'd0);
        $display("test match done");
    endtask
    task test_scratch;
        wr(8'h18, 8'h5a);
        u_remote_end.get(v);
        chk("remote read", 8'h5a, v);
        @(posedge clk_sys_i);
        #1 chk("remote idle", 8'h00, rs_rdata);
        u_remote_end.put(8'h55);
        rd(8'h18, v);
        chk("local read", 8'h55, v);
        fork
            wr(8'h18, 8'h11);
            u_remote_end.put(8'h22);
        join
        rd(8'h18, v);
        chk("collision", 8'h11, v);
        hdr(7'h30, 1'b0, 1'b0, 7'h00, 2'd0);
        $display("test scratch done");
    endtask

    initial begin
        #100000;
        errors++;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        test_regs;
        test_b2b;
        test_match;
        test_scratch;
        test_reset;
        stop_test;
    end
endmodule
`default_nettype wire
